// File: rtl/pts_pkg.sv
package pts_pkg;

   // timing clock and printed times
   localparam int CLK_PERIOD_PS = 10000;
   localparam int MIN_DUR_NS    = 50;
   localparam int RCV_LOW_NS    = 100;
   localparam int SCAN_LEAD_NS  = 1400;
   localparam int STROBE_LOW_NS = 25;
   localparam int GATE_LOW_NS   = 100;

   // counter width and derived cycle counts (least times round up)
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] MIN_DUR_CYC =
      CNT_W'((MIN_DUR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [CNT_W-1:0] RCV_LOW_CYC =
      CNT_W'((RCV_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [CNT_W-1:0] SCAN_LEAD_CYC =
      CNT_W'((SCAN_LEAD_NS * 1000) / CLK_PERIOD_PS);
   localparam logic [CNT_W-1:0] STROBE_LOW_CYC =
      CNT_W'((STROBE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [CNT_W-1:0] GATE_LOW_CYC =
      CNT_W'((GATE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

   // register offsets
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFF_CMD    = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_DUR    = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_TRIG   = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_SCAN   = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_ACQ    = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_WORD0  = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_WORD3  = 8'h1c;
   localparam logic [ADDR_W-1:0] OFF_WORD4  = 8'h20;

   // field positions
   localparam int CMD_BIT_LSB   = 0;
   localparam int CMD_WORD_LSB  = 5;
   localparam int CMD_LEVEL_POS = 8;
   localparam int CMD_WAIT_POS  = 9;
   localparam int CMD_TSEL_LSB  = 10;
   localparam int TRIG_EDGE_LSB = 0;
   localparam int TRIG_SCAN_LSB = 4;
   localparam int ACQ_DATA_LSB  = 0;
   localparam int ACQ_ADDR_LSB  = 16;
   localparam int STAT_REFUSED_POS = 3;

   // output word selects
   localparam logic [1:0] WSEL_BP = 2'h0;
   localparam logic [1:0] WSEL_W3 = 2'h1;
   localparam logic [1:0] WSEL_W4 = 2'h2;

   // reset values and bus answers
   localparam logic [31:0]      WORD_RST = 32'hffffffff;
   localparam logic [CNT_W-1:0] DUR_RST  = 16'h0005;
   localparam logic [7:0]       TRIG_RST = 8'h00;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_ARMED, SEQ_HOLD} pts_seq_e;

endpackage : pts_pkg

// File: rtl/pts_dur_timer.sv
module pts_dur_timer
(
   // clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   reset_n,
   // load request
   input  wire logic                   load,
   input  wire logic [pts_pkg::CNT_W-1:0] loadCount,
   // state
   output logic                        busy,
   output logic                        busyN,
   output logic                        last
);
   import pts_pkg::*;

   logic [CNT_W-1:0] count;

   // busy stands exactly loadCount cycles after the load edge
   assign last = busy && (count == CNT_W'(1));

   // busyN is kept as its own flop so pins come straight off a register
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         count <= '0;
         busy  <= 1'b0;
         busyN <= 1'b1;
      end
      else if (load && (loadCount != '0))
      begin
         count <= loadCount;
         busy  <= 1'b1;
         busyN <= 1'b0;
      end
      else if (last)
      begin
         count <= '0;
         busy  <= 1'b0;
         busyN <= 1'b1;
      end
      else if (busy)
      begin
         count <= count - CNT_W'(1);
      end
   end

endmodule : pts_dur_timer

// File: rtl/pts_trig_in.sv
module pts_trig_in
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic reset_n,
   // pin and mode
   input  wire logic trigPin,
   input  wire logic edgeMode,
   // conditioned trigger
   output logic      level,
   output logic      hit
);
   logic syncA;
   logic levelPrev;

   // edge mode fires once per rising edge, level mode while high
   assign hit = edgeMode ? (level && !levelPrev) : level;

   // two flops before anything looks at the pin
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         syncA     <= 1'b0;
         level     <= 1'b0;
         levelPrev <= 1'b0;
      end
      else
      begin
         syncA     <= trigPin;
         level     <= syncA;
         levelPrev <= level;
      end
   end

endmodule : pts_trig_in

// File: rtl/pts_sequencer.sv
// Added by the designer: the register offsets and the AXI4-Lite slave port.
module pts_sequencer
(
   // clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        reset_n,
   // axi4-lite write
   input  wire logic [pts_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   // axi4-lite read
   input  wire logic [pts_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   // external triggers
   input  wire logic                        extTrigger0,
   input  wire logic                        extTrigger1,
   input  wire logic                        extTrigger2,
   input  wire logic                        extTrigger3,
   // output words, active low
   output logic [31:0]                      controlOutputWord0_n,
   output logic [31:0]                      controlOutputWord3_n,
   output logic [31:0]                      controlOutputWord4_n,
   output logic                             gradientBlankX_n,
   output logic                             gradientBlankY_n,
   output logic                             gradientBlankZ_n,
   // scan and acquisition bus
   output logic                             receiverStartPulse_n,
   output logic                             preampGatePulse_n,
   output logic                             acqBusStrobe_n,
   output logic [7:0]                       acqBusAddr,
   output logic [15:0]                      acqBusData,
   // clock outputs
   output logic                             rcvClockOut,
   output logic                             gradClockOut
);
   import pts_pkg::*;

   logic              awHeld;
   logic              wHeld;
   logic [ADDR_W-1:0] wrAddr;
   logic [31:0]       wrData;
   logic [3:0]        wrStrb;
   logic [CNT_W-1:0]  durReg;
   logic [7:0]        trigCfg;
   logic              refused;
   pts_seq_e          seqState;
   logic [4:0]        pendBit;
   logic [1:0]        pendWord;
   logic              pendLevel;
   logic              pendWait;
   logic [1:0]        pendTsel;
   logic [CNT_W-1:0]  pendDur;
   logic [3:0]        trigLevel;
   logic [3:0]        trigHit;
   logic              seqBusy;
   logic              seqLast;
   logic              leadBusy;
   logic              leadLast;
   logic              gateBusy;
   logic              acqBusy;

   // write decode
   wire        wrFire   = awHeld && wHeld;
   wire [31:0] wrMask   = {{8{wrStrb[3]}}, {8{wrStrb[2]}},
                           {8{wrStrb[1]}}, {8{wrStrb[0]}}};
   wire        wrCmd    = wrFire && (wrAddr == OFF_CMD);
   wire        wrDur    = wrFire && (wrAddr == OFF_DUR);
   wire        wrTrig   = wrFire && (wrAddr == OFF_TRIG);
   wire        wrScan   = wrFire && (wrAddr == OFF_SCAN);
   wire        wrAcq    = wrFire && (wrAddr == OFF_ACQ);
   wire        wrStat   = wrFire && (wrAddr == OFF_STATUS);
   wire        wrMapped = wrCmd || wrDur || wrTrig || wrScan || wrAcq
                          || wrStat;

   // command launch; word select 3 names no word and is refused
   wire [1:0] cmdWord   = wrData[CMD_WORD_LSB +: 2];
   wire       cmdOk     = (seqState == SEQ_IDLE) && (cmdWord != 2'h3);
   wire       cmdAccept = wrCmd && cmdOk;
   wire       apply     = (seqState == SEQ_ARMED)
                          && (!pendWait || trigHit[pendTsel]);
   wire [CNT_W-1:0] holdCount =
      (durReg < MIN_DUR_CYC) ? MIN_DUR_CYC : durReg;

   // scan start from software or an enabled trigger
   wire scanBusy  = leadBusy || gateBusy;
   wire trigScan  = |(trigHit & trigCfg[TRIG_SCAN_LSB +: 4]);
   wire scanGo    = (wrScan || trigScan) && !scanBusy;
   wire acqGo     = wrAcq && !acqBusy;
   wire refuseSet = (wrCmd && !cmdOk) || (wrScan && scanBusy)
                    || (wrAcq && acqBusy);
   wire refuseClr = wrStat && wrStrb[0] && wrData[STAT_REFUSED_POS];

   // next output words; one bit changes per applied command
   wire [31:0] bitMask = 32'h00000001 << pendBit;
   wire [31:0] next_word0 =
      (apply && (pendWord == WSEL_BP)) ?
      (pendLevel ? (controlOutputWord0_n | bitMask)
                 : (controlOutputWord0_n & ~bitMask)) :
      controlOutputWord0_n;
   wire [31:0] next_word3 =
      (apply && (pendWord == WSEL_W3)) ?
      (pendLevel ? (controlOutputWord3_n | bitMask)
                 : (controlOutputWord3_n & ~bitMask)) :
      controlOutputWord3_n;
   wire [31:0] next_word4 =
      (apply && (pendWord == WSEL_W4)) ?
      (pendLevel ? (controlOutputWord4_n | bitMask)
                 : (controlOutputWord4_n & ~bitMask)) :
      controlOutputWord4_n;

   // read decode
   wire [31:0] statusWord = {24'h000000, trigLevel, refused, acqBusy,
                             scanBusy, seqState != SEQ_IDLE};
   wire [31:0] cmdWordRb  = {20'h00000, pendTsel, pendWait, pendLevel,
                             1'b0, pendWord, pendBit};
   wire rdMapped = (s_axi_araddr == OFF_CMD) || (s_axi_araddr == OFF_DUR)
                   || (s_axi_araddr == OFF_TRIG) || (s_axi_araddr == OFF_SCAN)
                   || (s_axi_araddr == OFF_ACQ)
                   || (s_axi_araddr == OFF_STATUS)
                   || (s_axi_araddr == OFF_WORD0)
                   || (s_axi_araddr == OFF_WORD3)
                   || (s_axi_araddr == OFF_WORD4);
   wire [31:0] rdValue =
      (s_axi_araddr == OFF_CMD)    ? cmdWordRb :
      (s_axi_araddr == OFF_DUR)    ? {16'h0000, durReg} :
      (s_axi_araddr == OFF_TRIG)   ? {24'h000000, trigCfg} :
      (s_axi_araddr == OFF_ACQ)    ? {8'h00, acqBusAddr, acqBusData} :
      (s_axi_araddr == OFF_STATUS) ? statusWord :
      (s_axi_araddr == OFF_WORD0)  ? controlOutputWord0_n :
      (s_axi_araddr == OFF_WORD3)  ? controlOutputWord3_n :
      (s_axi_araddr == OFF_WORD4)  ? controlOutputWord4_n : 32'h00000000;

   // write channels taken in either order, answered once both are held
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         awHeld        <= 1'b0;
         wHeld         <= 1'b0;
      end
      else
      begin
         if (s_axi_awready && s_axi_awvalid)
         begin
            s_axi_awready <= 1'b0;
            awHeld        <= 1'b1;
         end
         if (s_axi_wready && s_axi_wvalid)
         begin
            s_axi_wready <= 1'b0;
            wHeld        <= 1'b1;
         end
         if (wrFire)
         begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // write payload capture; needs no reset, only read after a fire
   always_ff @(posedge clk_sys)
   begin
      if (s_axi_awready && s_axi_awvalid)
         wrAddr <= s_axi_awaddr;
      if (s_axi_wready && s_axi_wvalid)
      begin
         wrData <= s_axi_wdata;
         wrStrb <= s_axi_wstrb;
      end
   end

   // read channel, one outstanding read
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end
      else if (s_axi_arready && s_axi_arvalid)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rdValue;
         s_axi_rresp   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // stored settings; refused flag set wins over its clear
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         durReg  <= DUR_RST;
         trigCfg <= TRIG_RST;
         refused <= 1'b0;
      end
      else
      begin
         if (wrDur)
            durReg <= (durReg & ~wrMask[15:0]) | (wrData[15:0] & wrMask[15:0]);
         if (wrTrig)
            trigCfg <= (trigCfg & ~wrMask[7:0]) | (wrData[7:0] & wrMask[7:0]);
         refused <= refuseSet || (refused && !refuseClr);
      end
   end

   // sequencer: arm, optionally wait for a trigger, then hold
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         seqState <= SEQ_IDLE;
      else
      begin
         unique case (seqState)
            SEQ_IDLE:  if (cmdAccept) seqState <= SEQ_ARMED;
            SEQ_ARMED: if (apply) seqState <= SEQ_HOLD;
            SEQ_HOLD:  if (seqLast) seqState <= SEQ_IDLE;
         endcase
      end
   end

   // pending command, latched at launch
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         pendBit   <= 5'h00;
         pendWord  <= WSEL_BP;
         pendLevel <= 1'b1;
         pendWait  <= 1'b0;
         pendTsel  <= 2'h0;
         pendDur   <= DUR_RST;
      end
      else if (cmdAccept)
      begin
         pendBit   <= wrData[CMD_BIT_LSB +: 5];
         pendWord  <= cmdWord;
         pendLevel <= wrData[CMD_LEVEL_POS];
         pendWait  <= wrData[CMD_WAIT_POS];
         pendTsel  <= wrData[CMD_TSEL_LSB +: 2];
         pendDur   <= holdCount;
      end
   end

   // words, blanks and bus payload; reset leaves words and blanks inactive high, bus address and data zero
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         controlOutputWord0_n <= WORD_RST;
         controlOutputWord3_n <= WORD_RST;
         controlOutputWord4_n <= WORD_RST;
         {gradientBlankZ_n, gradientBlankY_n, gradientBlankX_n} <= 3'h7;
         acqBusAddr <= 8'h00;
         acqBusData <= 16'h0000;
      end
      else
      begin
         controlOutputWord0_n <= next_word0;
         controlOutputWord3_n <= next_word3;
         controlOutputWord4_n <= next_word4;
         {gradientBlankZ_n, gradientBlankY_n, gradientBlankX_n}
            <= next_word0[31:29];
         if (acqGo)
         begin
            acqBusAddr <= wrData[ACQ_ADDR_LSB +: 8];
            acqBusData <= wrData[ACQ_DATA_LSB +: 16];
         end
      end
   end

   // half-rate clocks, identical, toggled every timing cycle
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         rcvClockOut  <= 1'b0;
         gradClockOut <= 1'b0;
      end
      else
      begin
         rcvClockOut  <= !rcvClockOut;
         gradClockOut <= !rcvClockOut;
      end
   end

   // hold timer, counts whole timing-clock periods
   pts_dur_timer u_seqTimer (.clk_sys(clk_sys), .reset_n(reset_n),
      .load(apply), .loadCount(pendDur),
      .busy(seqBusy), .busyN(), .last(seqLast));

   // scan: start pulse and lead to the preamp gate start together
   pts_dur_timer u_rcvTimer (.clk_sys(clk_sys), .reset_n(reset_n),
      .load(scanGo), .loadCount(RCV_LOW_CYC),
      .busy(), .busyN(receiverStartPulse_n), .last());
   pts_dur_timer u_leadTimer (.clk_sys(clk_sys), .reset_n(reset_n),
      .load(scanGo), .loadCount(SCAN_LEAD_CYC),
      .busy(leadBusy), .busyN(), .last(leadLast));
   pts_dur_timer u_gateTimer (.clk_sys(clk_sys), .reset_n(reset_n),
      .load(leadLast), .loadCount(GATE_LOW_CYC),
      .busy(gateBusy), .busyN(preampGatePulse_n), .last());

   // strobe low span; data latch on the rising edge is the far side's job
   pts_dur_timer u_acqTimer (.clk_sys(clk_sys), .reset_n(reset_n),
      .load(acqGo), .loadCount(STROBE_LOW_CYC),
      .busy(acqBusy), .busyN(acqBusStrobe_n), .last());

   // trigger conditioners, mode per input
   pts_trig_in u_ext_trigger_0 (.clk_sys(clk_sys), .reset_n(reset_n),
      .trigPin(extTrigger0), .edgeMode(trigCfg[TRIG_EDGE_LSB]),
      .level(trigLevel[0]), .hit(trigHit[0]));
   pts_trig_in u_ext_trigger_1 (.clk_sys(clk_sys), .reset_n(reset_n),
      .trigPin(extTrigger1), .edgeMode(trigCfg[TRIG_EDGE_LSB + 1]),
      .level(trigLevel[1]), .hit(trigHit[1]));
   pts_trig_in u_ext_trigger_2 (.clk_sys(clk_sys), .reset_n(reset_n),
      .trigPin(extTrigger2), .edgeMode(trigCfg[TRIG_EDGE_LSB + 2]),
      .level(trigLevel[2]), .hit(trigHit[2]));
   pts_trig_in u_ext_trigger_3 (.clk_sys(clk_sys), .reset_n(reset_n),
      .trigPin(extTrigger3), .edgeMode(trigCfg[TRIG_EDGE_LSB + 3]),
      .level(trigLevel[3]), .hit(trigHit[3]));

   // checks
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   sequence rcvLowSeq;
      ##9 !receiverStartPulse_n ##1 receiverStartPulse_n;
   endsequence
   sequence strobeLowSeq;
      !acqBusStrobe_n [*3] ##1 acqBusStrobe_n;
   endsequence

   AST_RCV_WIDTH: assert property ($fell(receiverStartPulse_n) |->
      rcvLowSeq) else $error("receiver start width wrong");
   AST_RCV_LEAD: assert property ($fell(receiverStartPulse_n) |->
      ##140 $fell(preampGatePulse_n)) else $error("gate lead wrong");
   AST_STROBE_LOW: assert property ($fell(acqBusStrobe_n) |->
      strobeLowSeq) else $error("strobe low span wrong");
   AST_ACQ_STABLE: assert property (!acqBusStrobe_n |=>
      $stable(acqBusData) && $stable(acqBusAddr))
      else $error("bus payload moved during strobe");
   AST_CLK_OUT: assert property (1'b1 |=>
      (rcvClockOut != $past(rcvClockOut)) && (rcvClockOut == gradClockOut))
      else $error("clock outputs not toggling together");
   AST_SET_HIGH: assert property (apply && pendLevel &&
      (pendWord == WSEL_W3) |=> controlOutputWord3_n[$past(pendBit)])
      else $error("set-high did not drive bit high");
   AST_SET_LOW: assert property (apply && !pendLevel &&
      (pendWord == WSEL_W4) |=> !controlOutputWord4_n[$past(pendBit)])
      else $error("set-low did not drive bit low");
   AST_HOLD: assert property (!apply |=> $stable(controlOutputWord0_n) &&
      $stable(controlOutputWord3_n) && $stable(controlOutputWord4_n))
      else $error("output word changed without command");
   AST_MIN_DUR: assert property (apply |=> !apply [*4])
      else $error("state shorter than minimum");
   AST_BLANK: assert property ({gradientBlankZ_n, gradientBlankY_n,
      gradientBlankX_n} == controlOutputWord0_n[31:29])
      else $error("blank outputs differ from word bits");
   AST_EDGE_TRIG: assert property (trigCfg[TRIG_EDGE_LSB] && trigHit[0]
      |=> !trigHit[0]) else $error("edge trigger longer than one cycle");
   AST_RESET_HIGH: assert property (disable iff (1'b0) !reset_n |=>
      (&controlOutputWord3_n) && (&controlOutputWord4_n) &&
      receiverStartPulse_n && acqBusStrobe_n && preampGatePulse_n)
      else $error("outputs not high after reset");

endmodule : pts_sequencer

// File: verification/pts_grad_model.sv
module pts_grad_model
(
   // acquisition bus
   input  wire logic        acqBusStrobe_n,
   input  wire logic [7:0]  acqBusAddr,
   input  wire logic [15:0] acqBusData,
   // last captured transfer
   output logic [23:0]      lastXfer
);
   timeunit 1ns;
   timeprecision 1ps;
   // falling edge is ignored, payload may still settle then
   initial lastXfer = 24'h000000;
   always @(posedge acqBusStrobe_n)
      lastXfer <= {acqBusAddr, acqBusData};
endmodule : pts_grad_model

// File: verification/tb_top.sv
module tb_top;
   import pts_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, reset_n, awv, wv, bready, arv, rready, gX, gY, gZ;
   logic awready, wready, bvalid, arready, rvalid, rcvClk, gradClk;
   logic rsp, pgp, strb;
   logic [7:0] awaddr, araddr, acqAddr;
   logic [31:0] wdata, rdata, rv, n, w0, w3, w4;
   logic [1:0] bresp, rresp, resp;
   logic [3:0] trig;
   logic [15:0] acqData;
   logic [23:0] xfer;
   logic [4:0] bitSel [3] = '{5'h1f, 5'h00, 5'h11};
   logic [7:0] wordOff [3] = '{OFF_WORD0, OFF_WORD3, OFF_WORD4};
   int num_errors = 0;
   int comparisons = 0;
   pts_sequencer i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .extTrigger0(trig[0]),
      .extTrigger1(trig[1]), .extTrigger2(trig[2]), .extTrigger3(trig[3]),
      .controlOutputWord0_n(w0), .controlOutputWord3_n(w3),
      .controlOutputWord4_n(w4), .gradientBlankX_n(gX), .gradientBlankY_n(gY),
      .gradientBlankZ_n(gZ), .receiverStartPulse_n(rsp),
      .preampGatePulse_n(pgp), .acqBusStrobe_n(strb), .acqBusAddr(acqAddr),
      .acqBusData(acqData), .rcvClockOut(rcvClk), .gradClockOut(gradClk));
   pts_grad_model i_grad (.acqBusStrobe_n(strb), .acqBusAddr(acqAddr),
      .acqBusData(acqData), .lastXfer(xfer));
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic stop_test(input int e);
      num_errors += e;
      if (num_errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // each channel held until its own handshake edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int k = 0;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         if (awready) awv <= 1'b0;
         if (wready) wv <= 1'b0;
         k++;
      end while (bvalid !== 1'b1 && k < 50);
      bready <= 1'b0;
      resp = bresp;
      if (k >= 50) stop_test(1);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      int k = 0;
      @(posedge clk_sys);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         if (arready) arv <= 1'b0;
         k++;
      end while (rvalid !== 1'b1 && k < 50);
      rready <= 1'b0;
      rv = rdata;
      resp = rresp;
      if (k >= 50) stop_test(1);
   endtask : rd
   // poll until sequencer, scan and strobe are all quiet
   task automatic idle();
      for (int i = 0; i < 100; i++)
      begin
         rd(OFF_STATUS);
         if (rv[2:0] === 3'h0) return;
      end
      stop_test(1);
   endtask : idle
   initial
   begin
      {reset_n, awv, wv, bready, arv, rready, trig} = 10'h000;
      {awaddr, araddr, wdata} = 48'h0;
      repeat (8) @(posedge clk_sys);
      chk(w0 & w3 & w4, WORD_RST);
      chk({26'h0, gX, gY, gZ, rsp, pgp, strb}, 32'h3f);
      reset_n <= 1'b1;
      rd(8'h40);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
      n = {31'h0, rcvClk};
      @(posedge clk_sys);
      chk({30'h0, rcvClk, gradClk}, {30'h0, ~n[0], ~n[0]});
      for (int i = 0; i < 3; i++)
      begin
         wr(OFF_CMD, {23'h0, 1'b0, 1'b0, i[1:0], bitSel[i]});
         idle();
         rd(wordOff[i]);
         chk(rv, ~(32'h1 << bitSel[i]));
         chk(w0 & w3 & w4, ~(32'h1 << bitSel[i]));
         wr(OFF_CMD, {23'h0, 1'b1, 1'b0, i[1:0], bitSel[i]});
         idle();
         chk(w0 & w3 & w4, WORD_RST);
      end
      wr(OFF_CMD, 32'h00000060);
      chk({30'h0, resp}, {30'h0, RESP_OKAY});
      rd(OFF_STATUS);
      chk({31'h0, rv[3]}, 32'h1);
      // edge mode on trigger 0: one hit per rising edge, held level no hit
      wr(OFF_TRIG, 32'h00000001);
      wr(OFF_CMD, 32'h00000222);
      trig[0] <= 1'b1;
      idle();
      chk(w3, ~32'h00000004);
      wr(OFF_CMD, 32'h00000322);
      rd(OFF_STATUS);
      chk({31'h0, rv[0]}, 32'h1);
      trig[0] <= 1'b0;
      repeat (4) @(posedge clk_sys);
      trig[0] <= 1'b1;
      idle();
      chk(w3, WORD_RST);
      // first low sample stands at the edge on which wr returns
      wr(OFF_ACQ, 32'h00a55a3c);
      n = {31'h0, ~strb};
      repeat (7) @(posedge clk_sys) n += {31'h0, ~strb};
      chk(n, {16'h0, STROBE_LOW_CYC});
      chk({8'h0, xfer}, 32'h00a55a3c);
      wr(OFF_SCAN, 32'h0);
      n = {31'h0, ~rsp};
      repeat (19) @(posedge clk_sys) n += {31'h0, ~rsp};
      chk(n, {16'h0, RCV_LOW_CYC});
      // n counts edges since the scan write took effect
      n = 32'd20;
      while (pgp !== 1'b0 && n < 300)
      begin
         @(posedge clk_sys);
         n++;
      end
      chk(n, {16'h0, SCAN_LEAD_CYC} + 32'd1);
      stop_test(0);
   end
endmodule : tb_top
